// ==== pkg/flash_status_pkg.sv ====
// constants for the program/erase status register and its read port
// assumes one 200 MHz clock and an active-low asynchronous reset
package flash_status_pkg;

  // bit positions within the eight-bit status word
  localparam int BIT_READY = 7;         // controller idle
  localparam int BIT_ERASE_SUSP = 6;    // erase paused, awaiting resume
  localparam int BIT_ERASE_FAIL = 5;    // erase verify gave up
  localparam int BIT_PROG_FAIL = 4;     // program verify failed
  localparam int BIT_ENABLE_VIOL = 3;   // attempt with enable pin low
  localparam int BIT_PROG_SUSP = 2;     // program paused, awaiting resume
  localparam int BIT_PROT_VIOL = 1;     // attempt on a protected block
  localparam int BIT_RESERVED = 0;      // always reads one

  // status word after reset: ready, no flags, reserved bit high
  localparam logic [7:0] STATUS_RESET = 8'h81;

  // mask of the sticky error flags that make a new operation fail
  localparam logic [7:0] ERROR_MASK = 8'h3a;

  // pin synchroniser lanes and their idle levels
  localparam int SYNC_WIDTH = 4;
  localparam int LANE_ENABLE_PIN = 0;
  localparam int LANE_CHIP_EN_N = 1;
  localparam int LANE_OUT_EN_N = 2;
  localparam int LANE_OUT_DIS = 3;
  localparam logic [3:0] SYNC_RESET = 4'h6;

  // read port states
  typedef enum logic [1:0] {
    RD_IDLE  = 2'b01,
    RD_DRIVE = 2'b10
  } read_state_t;

endpackage

// ==== core/status_read_port.sv ====
// data bus driver for the status word on the low data lines
// assumes read_active_in comes from synchronised pins on the same clock
`timescale 1ns/1ps
module status_read_port
  import flash_status_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic read_active_in,    // decoded status read cycle
  input wire logic [7:0] status_in,   // live status word
  output logic [7:0] data_out,        // low data lines
  output logic data_oe_out            // high while driving the lines
);

  read_state_t state;        // current drive state
  read_state_t next_state;   // next drive state
  wire start_read;           // first cycle of a read

  assign start_read = read_active_in && (state == RD_IDLE);

  // state choice: drive while the read stays active
  always_comb begin
    case (state)
      RD_IDLE: next_state = read_active_in ? RD_DRIVE : RD_IDLE;
      RD_DRIVE: next_state = read_active_in ? RD_DRIVE : RD_IDLE;
      default: next_state = RD_IDLE;
    endcase
  end

  // snapshot taken at read start; a fresh value needs the read to be re-opened
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= RD_IDLE;
      data_out <= 8'h00;
      data_oe_out <= 1'b0;
    end else begin
      state <= next_state;
      data_oe_out <= read_active_in;
      if (start_read) begin
        data_out <= status_in;
      end
    end
  end

  property p_read_drives;
    @(posedge clk_in) disable iff (!reset_n_in)
      start_read |=> data_oe_out && (data_out == $past(status_in));
  endproperty
  a_read_drives: assert property (p_read_drives) else $error("status read not driven");

endmodule

// ==== core/flash_status_register.sv ====
// status register of the program/erase controller, with operation gating
// assumes controller events are one-cycle pulses on clk_in; bus pins are asynchronous
//
// Functional notes
// - program suspend flag set while program paused
// - suspend flags meaningful only when ready reads one
// - accepted resume clears program suspend flag
// - protected block attempt sets flag, aborts
// - protection flag sticky until clear or reset
// - bit zero always reads one
// - bit seven is one when controller idle
// - status driven on low lines, any address
// - erase verify give-up sets sticky erase flag
// - attempt with enable pin low sets flag
`timescale 1ns/1ps
module flash_status_register
  import flash_status_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ctrl_busy_in,                  // controller running an algorithm
  input wire logic op_request_in,                 // pulse: program or erase requested
  input wire logic op_protected_in,               // target block is protected
  input wire logic program_erase_enable_pin_in,   // enable pin, asynchronous
  input wire logic erase_fail_in,                 // pulse: erase pulses exhausted
  input wire logic program_fail_in,               // pulse: program verify failed
  input wire logic erase_paused_in,               // pulse: erase entered suspend
  input wire logic program_paused_in,             // pulse: program entered suspend
  input wire logic resume_accept_in,              // pulse: resume command accepted
  input wire logic clear_status_in,               // pulse: clear status command
  input wire logic status_read_select_in,         // decoder in status read mode
  input wire logic chip_enable_n_in,              // chip enable pin, asynchronous
  input wire logic output_enable_n_in,            // output enable pin, asynchronous
  input wire logic output_disable_in,             // output disable pin, asynchronous
  output logic op_accept_out,                     // pulse: operation may start
  output logic op_abort_out,                      // pulse: operation refused
  output logic [7:0] status_out,                  // status word to the controller
  output logic [7:0] data_out,                    // low data lines
  output logic data_oe_out                        // drive enable of the data lines
);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  // error flags that make a request fail, used in two places
  function automatic logic has_error(input logic [7:0] word);
    has_error = |(word & ERROR_MASK);
  endfunction

  logic [SYNC_WIDTH-1:0] sync_meta;   // first stage, read only by the second
  logic [SYNC_WIDTH-1:0] sync_pins;   // second stage, safe to use
  wire [SYNC_WIDTH-1:0] raw_pins;     // pins gathered into lanes

  assign raw_pins[LANE_ENABLE_PIN] = program_erase_enable_pin_in;
  assign raw_pins[LANE_CHIP_EN_N] = chip_enable_n_in;
  assign raw_pins[LANE_OUT_EN_N] = output_enable_n_in;
  assign raw_pins[LANE_OUT_DIS] = output_disable_in;

  // two-flop synchroniser per pin lane
  genvar g;
  generate
    for (g = 0; g < SYNC_WIDTH; g++) begin : g_sync
      always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          sync_meta[g] <= SYNC_RESET[g];
          sync_pins[g] <= SYNC_RESET[g];
        end else begin
          sync_meta[g] <= raw_pins[g];
          sync_pins[g] <= sync_meta[g];
        end
      end
    end
  endgenerate

  wire enable_pin_high;   // synchronised enable pin level
  wire read_active;       // bus read of the status word in progress
  assign enable_pin_high = sync_pins[LANE_ENABLE_PIN];
  // address is not decoded: any address returns the status word
  assign read_active = status_read_select_in && !sync_pins[LANE_CHIP_EN_N] &&
                       !sync_pins[LANE_OUT_EN_N] && !sync_pins[LANE_OUT_DIS];

  // request screening
  wire viol_protect;    // request on a protected block
  wire viol_enable;     // request with enable pin low
  wire stale_error;     // an error flag is still set from before
  wire refuse;          // request must not start
  assign viol_protect = op_request_in && op_protected_in;
  assign viol_enable = op_request_in && !enable_pin_high;
  assign stale_error = op_request_in && has_error(status_out);
  // a leftover error makes the new command look failed; hosts should clear first
  assign refuse = viol_protect || viol_enable || stale_error;

  // next status word; every set term wins over the clear command
  wire keep;            // flags survive unless cleared
  wire [7:0] next_status;
  assign keep = !clear_status_in;
  assign next_status[BIT_READY] = !ctrl_busy_in;
  assign next_status[BIT_ERASE_SUSP] = erase_paused_in ||
                                       (status_out[BIT_ERASE_SUSP] && !resume_accept_in);
  assign next_status[BIT_ERASE_FAIL] = erase_fail_in || (status_out[BIT_ERASE_FAIL] && keep);
  assign next_status[BIT_PROG_FAIL] = program_fail_in || (status_out[BIT_PROG_FAIL] && keep);
  assign next_status[BIT_ENABLE_VIOL] = viol_enable || (status_out[BIT_ENABLE_VIOL] && keep);
  // suspend flag only rises on a real pause, so a finished operation leaves it low
  assign next_status[BIT_PROG_SUSP] = program_paused_in ||
                                      (status_out[BIT_PROG_SUSP] && !resume_accept_in);
  assign next_status[BIT_PROT_VIOL] = viol_protect || (status_out[BIT_PROT_VIOL] && keep);
  assign next_status[BIT_RESERVED] = 1'b1;

  // status word and request answers
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status_out <= STATUS_RESET;
      op_accept_out <= 1'b0;
      op_abort_out <= 1'b0;
    end else begin
      status_out <= next_status;
      op_accept_out <= op_request_in && !refuse;
      op_abort_out <= op_request_in && refuse;
    end
  end

  // bus side driver; suspend bits are only trustworthy with ready high
  status_read_port u_read_port (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .read_active_in(read_active),
    .status_in(status_out),
    .data_out(data_out),
    .data_oe_out(data_oe_out)
  );

  sequence s_bad_target;
    op_request_in && op_protected_in;
  endsequence

  sequence s_abort_with_flag;
    op_abort_out && !op_accept_out && status_out[BIT_PROT_VIOL];
  endsequence

  property p_prot_abort;
    s_bad_target |=> s_abort_with_flag;
  endproperty
  a_prot_abort: assert property (p_prot_abort) else $error("protected target not aborted");

  property p_prot_sticky;
    status_out[BIT_PROT_VIOL] && !clear_status_in |=> status_out[BIT_PROT_VIOL];
  endproperty
  a_prot_sticky: assert property (p_prot_sticky) else $error("protection flag dropped");

  property p_prot_clear;
    clear_status_in && !(op_request_in && op_protected_in) |=> !status_out[BIT_PROT_VIOL];
  endproperty
  a_prot_clear: assert property (p_prot_clear) else $error("protection flag not cleared");

  property p_ready;
    ##1 status_out[BIT_READY] == !$past(ctrl_busy_in);
  endproperty
  a_ready: assert property (p_ready) else $error("ready bit wrong");

  property p_reserved;
    status_out[BIT_RESERVED];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit low");

  property p_prog_susp_set;
    program_paused_in |=> status_out[BIT_PROG_SUSP];
  endproperty
  a_prog_susp_set: assert property (p_prog_susp_set) else $error("program suspend not set");

  property p_resume;
    resume_accept_in && !program_paused_in |=> !status_out[BIT_PROG_SUSP];
  endproperty
  a_resume: assert property (p_resume) else $error("resume left suspend set");

  property p_prog_susp_idle;
    !status_out[BIT_PROG_SUSP] && !program_paused_in |=> !status_out[BIT_PROG_SUSP];
  endproperty
  a_prog_susp_idle: assert property (p_prog_susp_idle) else $error("suspend rose by itself");

  property p_erase_fail;
    erase_fail_in |=> status_out[BIT_ERASE_FAIL] ##1 (status_out[BIT_ERASE_FAIL] || $past(clear_status_in));
  endproperty
  a_erase_fail: assert property (p_erase_fail) else $error("erase failure flag lost");

  property p_enable_viol;
    op_request_in && !enable_pin_high |=> status_out[BIT_ENABLE_VIOL] && op_abort_out;
  endproperty
  a_enable_viol: assert property (p_enable_viol) else $error("enable violation missed");

  property p_stale;
    op_request_in && has_error(status_out) |=> !op_accept_out;
  endproperty
  a_stale: assert property (p_stale) else $error("request accepted over old error");

endmodule

// ==== bench/bus_host.sv ====
// host bus controller model: reads the status word over the data lines
// assumes the status register sits on the same clk_in and is in status read mode
`timescale 1ns/1ps
module bus_host (
  input wire logic clk_in,
  input wire logic [7:0] data_in,      // low data lines from the device
  input wire logic data_oe_in,         // device drives the lines
  output logic chip_enable_n_out,      // chip enable, held active
  output logic output_enable_n_out,    // output enable, pulsed per read
  output logic output_disable_out      // output disable, held inactive
);
  initial begin
    chip_enable_n_out = 1'b0;
    output_enable_n_out = 1'b1;
    output_disable_out = 1'b0;
  end

  // one read cycle; no address at all, any location answers
  task automatic read_status(output logic [7:0] v, output logic got);
    int n;
    n = 0;
    @(posedge clk_in) output_enable_n_out <= 1'b0;
    // pins pass a synchroniser, so allow a bounded wait
    while (data_oe_in !== 1'b1 && n < 20) begin
      @(posedge clk_in);
      n++;
    end
    // a read that never saw the drive enable says so, so the caller can check got for a timeout
    got = (data_oe_in === 1'b1);
    v = data_in;
    @(posedge clk_in) output_enable_n_out <= 1'b1;
    // let the drive enable fall before the next read
    repeat (5) @(posedge clk_in);
  endtask
endmodule

// ==== bench/tb_top.sv ====
// self-checking bench for the program/erase status register
// assumes the status bus_host model and a 200 MHz clock
`timescale 1ns/1ps
module tb_top;
  import flash_status_pkg::*;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic busy = 1'b0, prot = 1'b0, en_pin = 1'b1, sel = 1'b1;
  logic [6:0] ev = 7'h00; // request, efail, pfail, epause, ppause, resume, clear
  logic ce_n, oe_n, od, acc, abt, oe;
  logic [7:0] st, dq, v;
  int errors = 0;
  int cmp_count = 0;

  always #2.5 clk_in = ~clk_in;

  flash_status_register uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .ctrl_busy_in(busy),
    .op_request_in(ev[0]), .op_protected_in(prot), .program_erase_enable_pin_in(en_pin),
    .erase_fail_in(ev[1]), .program_fail_in(ev[2]), .erase_paused_in(ev[3]),
    .program_paused_in(ev[4]), .resume_accept_in(ev[5]), .clear_status_in(ev[6]),
    .status_read_select_in(sel), .chip_enable_n_in(ce_n), .output_enable_n_in(oe_n),
    .output_disable_in(od), .op_accept_out(acc), .op_abort_out(abt), .status_out(st),
    .data_out(dq), .data_oe_out(oe));

  bus_host host (.clk_in(clk_in), .data_in(dq), .data_oe_in(oe), .chip_enable_n_out(ce_n),
    .output_enable_n_out(oe_n), .output_disable_out(od));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle event pulse, returns just after the answering edge
  task automatic pulse(input int i, input logic p = 1'b0);
    @(posedge clk_in) begin
      ev[i] <= 1'b1;
      prot <= p;
    end
    @(posedge clk_in) ev[i] <= 1'b0;
    #1;
  endtask

  task automatic t_busy;
    @(posedge clk_in) busy <= 1'b1;
    @(posedge clk_in) #1;
    check(st, 8'h01);
    @(posedge clk_in) busy <= 1'b0;
    @(posedge clk_in) #1;
    check(st, STATUS_RESET);
    $display("busy test done");
  endtask

  task automatic t_protect;
    pulse(0, 1'b1);
    check({6'h00, acc, abt}, 8'h01);
    check(st, 8'h83);
    pulse(0);
    check({6'h00, acc, abt}, 8'h01);
    check(st, 8'h83);
    pulse(6);
    check(st, STATUS_RESET);
    pulse(0);
    check({6'h00, acc, abt}, 8'h02);
    $display("protect test done");
  endtask

  task automatic t_enable_pin;
    @(posedge clk_in) en_pin <= 1'b0;
    repeat (3) @(posedge clk_in);
    pulse(0);
    check({6'h00, acc, abt}, 8'h01);
    check(st, 8'h89);
    pulse(6);
    @(posedge clk_in) en_pin <= 1'b1;
    repeat (3) @(posedge clk_in);
    $display("enable pin test done");
  endtask

  task automatic t_sticky;
    logic [7:0] exp [2] = '{8'ha1, 8'h91};
    for (int k = 0; k < 2; k++) begin
      pulse(k + 1);
      repeat (4) @(posedge clk_in);
      check(st, exp[k]);
      pulse(0);
      check({6'h00, acc, abt}, 8'h01);
      pulse(6);
      check(st, STATUS_RESET);
    end
    $display("sticky test done");
  endtask

  task automatic t_suspend;
    logic [7:0] exp [2] = '{8'hc1, 8'h85};
    for (int k = 0; k < 2; k++) begin
      pulse(k + 3);
      check({7'h00, st[BIT_READY]}, 8'h01);
      check(st, exp[k]);
      pulse(5);
      check(st, STATUS_RESET);
    end
    $display("suspend test done");
  endtask

  task automatic t_read;
    logic got;
    host.read_status(v, got);
    check({7'h00, got}, 8'h01);
    check(v, STATUS_RESET);
    check({7'h00, oe}, 8'h00);
    pulse(1);
    host.read_status(v, got);
    check({7'h00, got}, 8'h01);
    check(v, 8'ha1);
    pulse(6);
    // no drive while the decoder is out of status read mode
    @(posedge clk_in) sel <= 1'b0;
    host.read_status(v, got);
    check({7'h00, got}, 8'h00);
    @(posedge clk_in) sel <= 1'b1;
    $display("read test done");
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog well beyond the hundred-odd cycles the tests need
  initial begin
    #20000;
    errors++;
    give_verdict();
  end

  initial begin
    repeat (16) @(posedge clk_in);
    reset_n_in <= 1'b1;
    // enable pin synchroniser needs edges to settle
    repeat (3) @(posedge clk_in);
    #1;
    check(st, STATUS_RESET);
    t_busy();
    t_protect();
    t_enable_pin();
    t_sticky();
    t_suspend();
    t_read();
    give_verdict();
  end
endmodule
